// [verilog/itc_top.v]
// Interrupt clear registers and transmit threshold of an I2C controller.
// Assumes APB master and all event inputs on the same clock and reset.
//
// What this block does
// - Eight-bit read-write transmit threshold, reset zero; drives transmit-empty flag bit 4.
// - Threshold writes above the transmit buffer depth store the depth.
// - Threshold N means exactly N entries, no offset of one.
// - All-clear read clears combined interrupt, soft flags and abort cause record.
// - All-clear read leaves hardware-cleared flags alone.
// - Abort cause clear keeps the bit 9 exception instead of clearing it.
// - Read at 0x44 clears receive underflow flag, bit 0.
// - Read at 0x48 clears receive overflow flag, bit 1.
// - Read at 0x4c clears transmit overflow flag, bit 3.
// - Read at 0x50 clears read request flag, bit 5.
// - Read at 0x54 clears transmit abort flag bit 6 and cause record.
// - Read at 0x54 releases the transmit FIFO from its flushed hold.
// - Read at 0x58 clears receive finished flag, bit 7.
// - Transmit-empty flag drops by itself once level exceeds threshold.
`timescale 1ns/1ns
`default_nettype none
`include "itc_defines.vh"

module itc_top #(
	parameter TX_DEPTH = 16, // Transmit buffer depth in entries
	parameter LEVEL_W = 9 // Width of the FIFO level input
) (
	input wire clock, // System clock, 100 MHz
	input wire rst, // Async reset, active high
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction, high for write
	input wire [7:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error for unmapped address
	input wire [LEVEL_W-1:0] transmit_fifo_level, // Entries in transmit FIFO
	input wire receive_full_level, // Receive FIFO at its threshold
	input wire receive_underflow_event, // Pulse: read of empty receive FIFO
	input wire receive_overflow_event, // Pulse: byte lost, receive FIFO full
	input wire transmit_overflow_event, // Pulse: write to full transmit FIFO
	input wire read_request_event, // Pulse: remote master wants data
	input wire transmit_abort_event, // Pulse: transmit aborted
	input wire receive_finished_event, // Pulse: remote master ended read
	input wire abort_bit9_release, // Cause of record bit 9 has gone
	output reg [7:0] raw_interrupt_status, // Raw flags
	output reg [7:0] transmit_threshold_level, // Stored threshold
	output reg transmit_abort_cause_clear, // Pulse: clear cause record
	output reg abort_cause_keep_bit9, // Spare bit 9 on that clear
	output reg transmit_fifo_hold, // Transmit FIFO flushed and held
	output reg irq // Combined interrupt, level
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// A depth of 256 would not fit the threshold field; 255 is the top
	// Declared ahead of the clamp function, which reads it
	localparam [8:0] DEPTH9 = (TX_DEPTH > 255) ? 9'h0FF : TX_DEPTH[8:0];

	// Clamp a written threshold to the buffer depth
	function [7:0] clamp_threshold;
		input [7:0] value;
		begin
			if ({1'b0, value} > DEPTH9) begin
				clamp_threshold = DEPTH9[7:0];
			end else begin
				clamp_threshold = value;
			end
		end
	endfunction

	// Word of a one-bit clear register
	// Upper bits are reserved and always read as zero
	function [31:0] bit0_word;
		input flag;
		begin
			bit0_word = {31'h0000_0000, flag};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus decode

	wire setup_phase;
	wire access_done;
	wire rd_done;
	wire wr_done;
	reg addr_hit;

	assign setup_phase = psel & ~penable;
	// Effects land only on the completing access edge
	assign access_done = psel & penable & pready;
	assign rd_done = access_done & ~pwrite & ~pslverr;
	assign wr_done = access_done & pwrite & ~pslverr;

	// Address map check
	// Unmapped offsets answer with pslverr and zero data, no side effect
	always @* begin
		if (paddr == `ITC_OFS_TX_THRESHOLD) begin
			addr_hit = 1'b1;
		end else if (paddr == `ITC_OFS_CLR_ALL) begin
			addr_hit = 1'b1;
		end else if (paddr == `ITC_OFS_RECEIVE_UNDERFLOW_CLEAR_BIT) begin
			addr_hit = 1'b1;
		end else if (paddr == `ITC_OFS_RECEIVE_OVERFLOW_CLEAR_BIT) begin
			addr_hit = 1'b1;
		end else if (paddr == `ITC_OFS_TRANSMIT_OVERFLOW_CLEAR_BIT) begin
			addr_hit = 1'b1;
		end else if (paddr == `ITC_OFS_READ_REQUEST_CLEAR_BIT) begin
			addr_hit = 1'b1;
		end else if (paddr == `ITC_OFS_CLR_TX_ABORT) begin
			addr_hit = 1'b1;
		end else if (paddr == `ITC_OFS_RECEIVE_FINISHED_CLEAR_BIT) begin
			addr_hit = 1'b1;
		end else if (paddr == `ITC_OFS_IRQ_STATUS) begin
			addr_hit = 1'b1;
		end else if (paddr == `ITC_OFS_IRQ_MASK) begin
			addr_hit = 1'b1;
		end else if (paddr == `ITC_OFS_RAW_STATUS) begin
			addr_hit = 1'b1;
		end else begin
			addr_hit = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read-to-clear strobes, only on completed reads

	wire clr_all;
	wire clr_abort;
	wire status_rd;
	reg [7:0] clr_one;

	// Errored reads never clear: rd_done already excludes them
	assign clr_all = rd_done & (paddr == `ITC_OFS_CLR_ALL);
	assign clr_abort = rd_done & (paddr == `ITC_OFS_CLR_TX_ABORT);
	assign status_rd = rd_done & (paddr == `ITC_OFS_IRQ_STATUS);

	// Per-flag clear from the individual registers; writes never clear
	always @* begin
		clr_one = 8'h00;
		clr_one[`ITC_BIT_RX_UNDER] = rd_done & (paddr == `ITC_OFS_RECEIVE_UNDERFLOW_CLEAR_BIT);
		clr_one[`ITC_BIT_RX_OVER] = rd_done & (paddr == `ITC_OFS_RECEIVE_OVERFLOW_CLEAR_BIT);
		clr_one[`ITC_BIT_TX_OVER] = rd_done & (paddr == `ITC_OFS_TRANSMIT_OVERFLOW_CLEAR_BIT);
		clr_one[`ITC_BIT_RD_REQ] = rd_done & (paddr == `ITC_OFS_READ_REQUEST_CLEAR_BIT);
		clr_one[`ITC_BIT_TX_ABORT] = clr_abort;
		clr_one[`ITC_BIT_RX_DONE] = rd_done & (paddr == `ITC_OFS_RECEIVE_FINISHED_CLEAR_BIT);
	end

	////////////////////////////////////////////////////////////////////////
	// Threshold register and transmit-empty level

	// Both sides one bit wider than the level, so no compare can wrap
	localparam CMP_W = LEVEL_W + 1;

	wire tx_empty_now;
	wire [CMP_W-1:0] level_ext;
	wire [CMP_W-1:0] thresh_ext;

	assign level_ext = {1'b0, transmit_fifo_level};
	assign thresh_ext = {{(CMP_W - 8){1'b0}}, transmit_threshold_level};
	// Exact compare, zero threshold fires only on an empty FIFO
	assign tx_empty_now = (level_ext <= thresh_ext);

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			transmit_threshold_level <= `ITC_RST_THRESHOLD;
		end else if (wr_done & (paddr == `ITC_OFS_TX_THRESHOLD)) begin
			transmit_threshold_level <= clamp_threshold(pwdata[7:0]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Raw flags and pending interrupt bits

	wire [7:0] flag_set;
	wire [7:0] flag_clr;
	wire [7:0] flag_q;
	wire [7:0] pend_q;
	wire [7:0] hw_level;
	reg [7:0] raw_prev_q;
	wire [7:0] raw_rise;

	// Event inputs are one-cycle pulses from logic on this clock
	// Hardware flags follow their level; software flags latch events
	assign hw_level = {3'b000, tx_empty_now, 1'b0, receive_full_level, 2'b00};
	assign flag_set = (hw_level & ~`ITC_SW_CLEARABLE)
		| {receive_finished_event, transmit_abort_event, read_request_event,
		1'b0, transmit_overflow_event, 1'b0, receive_overflow_event,
		receive_underflow_event};
	// All-clear only touches software flags; hardware flags drop on level
	assign flag_clr = ((clr_one | {8{clr_all}}) & `ITC_SW_CLEARABLE)
		| (~hw_level & ~`ITC_SW_CLEARABLE);
	assign raw_rise = flag_q & ~raw_prev_q;

	genvar gi;
	generate
		for (gi = 0; gi < `ITC_FLAG_W; gi = gi + 1) begin : g_flag
			itc_sticky_flag u_raw (
				.clock(clock),
				.rst(rst),
				.set(flag_set[gi]),
				.clear(flag_clr[gi]),
				.flag_q(flag_q[gi])
			);
			// Pending bits: sticky on each raw rise, cleared by status read
			itc_sticky_flag u_pend (
				.clock(clock),
				.rst(rst),
				.set(raw_rise[gi]),
				.clear(status_rd | clr_all),
				.flag_q(pend_q[gi])
			);
		end
	endgenerate

	// Edge history for pending bits
	// Reset value equals the flags' reset, so no false rise after reset
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			raw_prev_q <= `ITC_RST_FLAGS;
		end else begin
			raw_prev_q <= flag_q;
		end
	end

	// Registered views of the flags
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			raw_interrupt_status <= `ITC_RST_FLAGS;
		end else begin
			raw_interrupt_status <= flag_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt mask and combined output

	// Mask bits share the raw status layout
	reg [7:0] mask_q;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			mask_q <= `ITC_RST_MASK;
		end else if (wr_done & (paddr == `ITC_OFS_IRQ_MASK)) begin
			mask_q <= pwdata[7:0];
		end
	end

	// Combined line, dropped by the all-clear through the pending bits
	// Registered so irq comes from a flip-flop, at one cycle of latency
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(pend_q & mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Abort cause record clear and transmit FIFO hold

	// One pulse per clearing read; bit 9 spared while its cause lasts
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			transmit_abort_cause_clear <= 1'b0;
			abort_cause_keep_bit9 <= 1'b0;
		end else begin
			transmit_abort_cause_clear <= clr_all | clr_abort;
			abort_cause_keep_bit9 <= ~abort_bit9_release;
		end
	end

	// Abort flushes and holds the FIFO until software acknowledges
	// A fresh abort beats the release read, so a new abort stays flushed
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			transmit_fifo_hold <= 1'b0;
		end else if (transmit_abort_event) begin
			transmit_fifo_hold <= 1'b1;
		end else if (clr_abort) begin
			transmit_fifo_hold <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB answer: no wait state, data and ready from flip-flops

	reg [31:0] rdata_d;

	// Read mux; clear registers show their flag in bit 0 only
	// Read data is the flag before the clearing edge takes effect
	always @* begin
		if (paddr == `ITC_OFS_TX_THRESHOLD) begin
			rdata_d = {24'h00_0000, transmit_threshold_level};
		end else if (paddr == `ITC_OFS_CLR_ALL) begin
			rdata_d = bit0_word(|(pend_q & mask_q));
		end else if (paddr == `ITC_OFS_RECEIVE_UNDERFLOW_CLEAR_BIT) begin
			rdata_d = bit0_word(flag_q[`ITC_BIT_RX_UNDER]);
		end else if (paddr == `ITC_OFS_RECEIVE_OVERFLOW_CLEAR_BIT) begin
			rdata_d = bit0_word(flag_q[`ITC_BIT_RX_OVER]);
		end else if (paddr == `ITC_OFS_TRANSMIT_OVERFLOW_CLEAR_BIT) begin
			rdata_d = bit0_word(flag_q[`ITC_BIT_TX_OVER]);
		end else if (paddr == `ITC_OFS_READ_REQUEST_CLEAR_BIT) begin
			rdata_d = bit0_word(flag_q[`ITC_BIT_RD_REQ]);
		end else if (paddr == `ITC_OFS_CLR_TX_ABORT) begin
			rdata_d = bit0_word(flag_q[`ITC_BIT_TX_ABORT]);
		end else if (paddr == `ITC_OFS_RECEIVE_FINISHED_CLEAR_BIT) begin
			rdata_d = bit0_word(flag_q[`ITC_BIT_RX_DONE]);
		end else if (paddr == `ITC_OFS_IRQ_STATUS) begin
			rdata_d = {24'h00_0000, pend_q};
		end else if (paddr == `ITC_OFS_IRQ_MASK) begin
			rdata_d = {24'h00_0000, mask_q};
		end else if (paddr == `ITC_OFS_RAW_STATUS) begin
			rdata_d = {24'h00_0000, flag_q};
		end else begin
			rdata_d = `ITC_RST_DATA;
		end
	end

	// Ready rises in the first access cycle; data sampled at setup
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `ITC_RST_DATA;
		end else if (setup_phase) begin
			pready <= 1'b1;
			pslverr <= ~addr_hit;
			prdata <= (pwrite | ~addr_hit) ? `ITC_RST_DATA : rdata_d;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `ITC_RST_DATA;
		end
	end

endmodule

`default_nettype wire

// [verilog/itc_defines.vh]
// Constants for the interrupt clear and transmit threshold block.
// Assumes inclusion by bare name from the design files.
`ifndef ITC_DEFINES_VH
`define ITC_DEFINES_VH

// Register byte offsets
`define ITC_OFS_TX_THRESHOLD 8'h3C
`define ITC_OFS_CLR_ALL 8'h40
`define ITC_OFS_RECEIVE_UNDERFLOW_CLEAR_BIT 8'h44
`define ITC_OFS_RECEIVE_OVERFLOW_CLEAR_BIT 8'h48
`define ITC_OFS_TRANSMIT_OVERFLOW_CLEAR_BIT 8'h4C
`define ITC_OFS_READ_REQUEST_CLEAR_BIT 8'h50
`define ITC_OFS_CLR_TX_ABORT 8'h54
`define ITC_OFS_RECEIVE_FINISHED_CLEAR_BIT 8'h58
`define ITC_OFS_IRQ_STATUS 8'h80
`define ITC_OFS_IRQ_MASK 8'h84
`define ITC_OFS_RAW_STATUS 8'h88

// Raw status bit positions
`define ITC_BIT_RX_UNDER 0
`define ITC_BIT_RX_OVER 1
`define ITC_BIT_RX_FULL 2
`define ITC_BIT_TX_OVER 3
`define ITC_BIT_TX_EMPTY 4
`define ITC_BIT_RD_REQ 5
`define ITC_BIT_TX_ABORT 6
`define ITC_BIT_RX_DONE 7

// Flags that software may clear; the rest follow hardware only
`define ITC_SW_CLEARABLE 8'hEB
`define ITC_FLAG_W 8

// Reset values
`define ITC_RST_THRESHOLD 8'h00
`define ITC_RST_MASK 8'h00
`define ITC_RST_FLAGS 8'h00
`define ITC_RST_DATA 32'h0000_0000

`endif

// [verilog/itc_sticky_flag.v]
// One flag with set and clear inputs, set winning.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module itc_sticky_flag (
	input wire clock, // System clock
	input wire rst, // Async reset, active high
	input wire set, // Set request
	input wire clear, // Clear request
	output reg flag_q // Flag state
);

	////////////////////////////////////////////////////////////////////////
	// Set beats clear so an event in the clearing cycle is kept
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			flag_q <= 1'b0;
		end else if (set) begin
			flag_q <= 1'b1;
		end else if (clear) begin
			flag_q <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// [dv/itc_chk.sv]
// Port assertions for the interrupt clear and threshold block.
// Assumes one clock domain and the design's async reset.
`timescale 1ns/1ns
`default_nettype none

module itc_chk #(
	parameter TX_DEPTH = 16, // Buffer depth
	parameter LEVEL_W = 9 // Level width
) (
	input wire clock, // Clock
	input wire rst, // Reset
	input wire psel, // APB
	input wire penable, // APB
	input wire pwrite, // APB
	input wire [7:0] paddr, // APB
	input wire [31:0] pwdata, // APB
	input wire [31:0] prdata, // APB
	input wire pready, // APB
	input wire pslverr, // APB
	input wire [LEVEL_W-1:0] transmit_fifo_level, // Level
	input wire receive_underflow_event, // Event
	input wire transmit_abort_event, // Event
	input wire [7:0] raw_interrupt_status, // Flags
	input wire [7:0] transmit_threshold_level, // Threshold
	input wire transmit_abort_cause_clear, // Pulse
	input wire transmit_fifo_hold // Level
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////
	// Taken accesses and the flags each clear read touches
	wire rd_acc = psel && penable && pready && !pwrite;
	wire wr_acc = psel && penable && pready && pwrite;
	wire [7:0] wr_clamp = (pwdata[7:0] > TX_DEPTH) ? TX_DEPTH[7:0] : pwdata[7:0];
	reg [7:0] clr_m;
	// Underflow and abort events are held off in the checked cycle, so set-wins is not confused with a miss
	always @* begin
		case (paddr)
			8'h40: clr_m = 8'hEB;
			8'h44: clr_m = 8'h01;
			8'h48: clr_m = 8'h02;
			8'h4C: clr_m = 8'h08;
			8'h50: clr_m = 8'h20;
			8'h54: clr_m = 8'h40;
			8'h58: clr_m = 8'h80;
			default: clr_m = 8'h00;
		endcase
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence

	////////////////////////////////////////////////////////////////
	chk_ready_after_setup: assert property (s_setup |=> s_access)
		else $error("no ready after setup");
	chk_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_thresh_clamp: assert property (wr_acc && paddr == 8'h3C |=>
		transmit_threshold_level == $past(wr_clamp)) else $error("threshold not clamped");
	chk_empty_set: assert property ((transmit_fifo_level <= transmit_threshold_level)[*4]
		|-> raw_interrupt_status[4]) else $error("empty flag missing");
	chk_empty_drop: assert property ((transmit_fifo_level > transmit_threshold_level)[*4]
		|-> !raw_interrupt_status[4]) else $error("empty flag stuck");
	chk_read_clears: assert property (rd_acc && !receive_underflow_event && !transmit_abort_event
		|-> ##2 (raw_interrupt_status & $past(clr_m, 2)) == 8'h00) else $error("flag not cleared");
	chk_set_wins: assert property (rd_acc && paddr == 8'h44 && receive_underflow_event
		|-> ##2 raw_interrupt_status[0]) else $error("set lost to clear");
	chk_cause_pulse: assert property (transmit_abort_cause_clear |->
		$past(rd_acc && (paddr == 8'h40 || paddr == 8'h54))) else $error("stray cause clear");
	chk_hold_set: assert property (transmit_abort_event |=> transmit_fifo_hold)
		else $error("hold not set");
	chk_hold_release: assert property (rd_acc && paddr == 8'h54 && !transmit_abort_event
		|=> !transmit_fifo_hold) else $error("hold not released");
	chk_clear_upper: assert property (rd_acc && paddr >= 8'h40 && paddr <= 8'h58
		|-> prdata[31:1] == 31'h0) else $error("upper bits set");
	chk_unmapped_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error with data");
endmodule

bind itc_top itc_chk #(.TX_DEPTH(TX_DEPTH), .LEVEL_W(LEVEL_W)) u_chk (.clock(clock), .rst(rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .transmit_fifo_level(transmit_fifo_level),
	.receive_underflow_event(receive_underflow_event), .transmit_abort_event(transmit_abort_event),
	.raw_interrupt_status(raw_interrupt_status), .transmit_threshold_level(transmit_threshold_level),
	.transmit_abort_cause_clear(transmit_abort_cause_clear), .transmit_fifo_hold(transmit_fifo_hold));
`default_nettype wire

// [dv/itc_top_test.sv]
// Self-checking bench for the interrupt clear and threshold block.
// Assumes the design and checker files are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end

module itc_top_test;
	logic clock, rst, psel, penable, pwrite, rx_full, b9_rel, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, rdata;
	logic [8:0] level;
	logic [5:0] ev;
	wire [31:0] prdata;
	wire pready, pslverr, cclr, keep9, hold, irq;
	wire [7:0] raw, thr;
	int errors, checks_done;
	localparam logic [7:0] ADR[6] = '{8'h44, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h58};
	localparam int BIT[6] = '{0, 1, 3, 5, 6, 7};
	localparam logic [7:0] TV[5] = '{8'h00, 8'h05, 8'h10, 8'h11, 8'hFF};

	itc_top #(.TX_DEPTH(16), .LEVEL_W(9)) dut (.clock(clock), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .transmit_fifo_level(level),
		.receive_full_level(rx_full), .receive_underflow_event(ev[0]),
		.receive_overflow_event(ev[1]), .transmit_overflow_event(ev[2]),
		.read_request_event(ev[3]), .transmit_abort_event(ev[4]),
		.receive_finished_event(ev[5]), .abort_bit9_release(b9_rel),
		.raw_interrupt_status(raw), .transmit_threshold_level(thr),
		.transmit_abort_cause_clear(cclr), .abort_cause_keep_bit9(keep9),
		.transmit_fifo_hold(hold), .irq(irq));

	////////////////////////////////////////////////////////////////
	// Closing report, APB master and small helpers
	task print_verdict;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Read data is taken at the ready edge, before that edge's updates land
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (i = 0; i < 8; i++) begin
			@(posedge clock);
			if (pready === 1'b1) break;
		end
		if (i == 8) begin
			errors++;
			print_verdict;
		end
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task negs(input int n);
		repeat (n) @(negedge clock);
	endtask
	task pulse(input int k);
		@(posedge clock);
		ev[k] <= 1'b1;
		@(posedge clock);
		ev <= 6'h00;
	endtask
	task set_level(input logic [8:0] v);
		@(posedge clock);
		level <= v;
		negs(3);
	endtask

	////////////////////////////////////////////////////////////////
	// Scenarios
	task t_threshold;
		apb(1'b0, 8'h3C, 32'h0);
		`CHK("threshold reset", 32'h0, rdata)
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, 8'h3C, {24'hFFFFFF, TV[i]});
			apb(1'b0, 8'h3C, 32'h0);
			`CHK("threshold", (TV[i] > 16) ? 32'h10 : {24'h0, TV[i]}, rdata)
		end
		apb(1'b1, 8'h3C, 32'h5);
		set_level(9'h005);
		`CHK("empty at level", 1'b1, raw[4])
		set_level(9'h006);
		`CHK("empty above", 1'b0, raw[4])
		set_level(9'h000);
	endtask
	task t_clears;
		for (int i = 0; i < 6; i++) begin
			pulse(i);
			negs(2);
			apb(1'b1, ADR[i], 32'hFFFFFFFF);
			negs(2);
			`CHK("flag kept", 1'b1, raw[BIT[i]])
			apb(1'b0, ADR[i], 32'h0);
			`CHK("clear data", 32'h1, rdata)
			negs(2);
			`CHK("flag cleared", 1'b0, raw[BIT[i]])
		end
	endtask
	task t_all;
		@(posedge clock);
		rx_full <= 1'b1;
		ev <= 6'h3F;
		@(posedge clock);
		ev <= 6'h00;
		negs(2);
		`CHK("all set", 8'hFF, raw)
		apb(1'b0, 8'h40, 32'h0);
		negs(1);
		`CHK("cause clear all", 1'b1, cclr)
		negs(1);
		`CHK("all cleared", 8'h14, raw)
		@(posedge clock);
		rx_full <= 1'b0;
	endtask
	task t_abort;
		apb(1'b0, 8'h54, 32'h0);
		pulse(4);
		negs(2);
		`CHK("fifo held", 1'b1, hold)
		`CHK("keep bit9", 1'b1, keep9)
		@(posedge clock);
		b9_rel <= 1'b1;
		negs(2);
		`CHK("drop bit9", 1'b0, keep9)
		apb(1'b0, 8'h54, 32'h0);
		negs(1);
		`CHK("cause clear", 1'b1, cclr)
		`CHK("fifo freed", 1'b0, hold)
		negs(1);
		`CHK("cause clear end", 1'b0, cclr)
	endtask
	task t_set_wins;
		fork
			apb(1'b0, 8'h44, 32'h0);
			begin
				repeat (2) @(posedge clock);
				ev[0] <= 1'b1;
				@(posedge clock);
				ev[0] <= 1'b0;
			end
		join
		negs(2);
		`CHK("set wins", 1'b1, raw[0])
		apb(1'b0, 8'h44, 32'h0);
	endtask
	task t_irq;
		pulse(1);
		negs(3);
		`CHK("irq masked", 1'b0, irq)
		apb(1'b1, 8'h84, 32'h2);
		negs(2);
		`CHK("irq raised", 1'b1, irq)
		apb(1'b0, 8'h80, 32'h0);
		`CHK("pending bit", 1'b1, rdata[1])
		negs(2);
		`CHK("irq cleared", 1'b0, irq)
		apb(1'b0, 8'h48, 32'h0);
		pulse(1);
		negs(3);
		`CHK("irq again", 1'b1, irq)
		apb(1'b0, 8'h40, 32'h0);
		negs(2);
		`CHK("irq all clear", 1'b0, irq)
		apb(1'b0, 8'h30, 32'h0);
		`CHK("unmapped err", 1'b1, err)
	endtask
	task t_reset;
		pulse(3);
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		negs(1);
		`CHK("reset raw", 8'h00, raw)
		`CHK("reset threshold", 8'h00, thr)
		negs(2);
		`CHK("empty after reset", 1'b1, raw[4])
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		{rst, psel, penable, pwrite, rx_full, b9_rel} = 6'h20;
		{paddr, pwdata, level, ev} = '0;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		t_threshold;
		t_clears;
		t_all;
		t_abort;
		t_set_wins;
		t_irq;
		t_reset;
		print_verdict;
	end
endmodule
`default_nettype wire
